/* src/gtr_map.svh */
`ifndef GTR_MAP_SVH
`define GTR_MAP_SVH
// Register indices; byte address is four times the index
`define GTR_IDX_COUNT_VALUE   10'h20c
`define GTR_IDX_COUNT_HIGH    10'h20d
`define GTR_IDX_TIMER_CTRL    10'h20e
`define GTR_IDX_GATE_CTRL     10'h20f
`define GTR_IDX_GATE_SRC      10'h210
`define GTR_IDX_CLK_SRC       10'h211
`define GTR_IDX_EVENT_STATUS  10'h212
// Field positions
`define GTR_TC_PS_LSB         4
`define GTR_TC_SYNC           2
`define GTR_TC_WIDE           1
`define GTR_TC_RUN            0
`define GTR_GC_GE             7
`define GTR_GC_GATE_POLARITY           6
`define GTR_GC_GTM            5
`define GTR_GC_GATE_SINGLE_PULSE_MODE           4
`define GTR_GC_GO             3
`define GTR_GC_GATE_LEVEL_STATUS           2
`define GTR_ST_OVF            0
`define GTR_ST_GEVT           1
// Clock source codes
`define GTR_CS_PIN            5'h00
`define GTR_CS_INSTR          5'h01
`define GTR_CS_SYSTEM         5'h02
`define GTR_CS_FAST           5'h03
`define GTR_CS_SLOW           5'h04
`define GTR_CS_ONE_MHZ        5'h05
`define GTR_CS_MED_500K       5'h06
`define GTR_CS_MED_32K        5'h07
`define GTR_CS_SMALL_TIMER    5'h08
// Gate source codes
`define GTR_GS_PIN            5'h00
`define GTR_GS_SMALL_TIMER    5'h01
`define GTR_GS_PERIOD_TIMER   5'h02
`define GTR_GS_CAPCOMP_ONE    5'h03
`define GTR_GS_CAPCOMP_TWO    5'h04
`define GTR_GS_PWM_THREE      5'h05
`define GTR_GS_PWM_FOUR       5'h06
// Misc
`define GTR_INSTR_DIV_LAST    2'h3
`define GTR_COUNT_MAX         16'hffff
`define GTR_RESP_OKAY         2'h0
`define GTR_RESP_DECERR       2'h3
`endif

/* src/gtr_pkg.sv */
package gtr_pkg;
  typedef struct packed {
    logic one_megahertz_oscillator;
    logic medium_internal_oscillator_32k;
    logic medium_internal_oscillator_500k;
    logic slow_internal_oscillator;
    logic fast_internal_oscillator;
    logic small_timer_output;
    logic pin;
  } gtr_clk_src_t;
  typedef struct packed {
    logic pulse_width_four_output;
    logic pulse_width_three_output;
    logic capcomp_two_output;
    logic capcomp_one_output;
    logic period_timer_output;
    logic small_timer_output;
    logic pin;
  } gtr_gate_src_t;
  typedef enum logic [0:0] {WR_IDLE, WR_RESP} gtr_wr_state_t;
  typedef enum logic [0:0] {RD_IDLE, RD_DATA} gtr_rd_state_t;
  typedef struct packed {
    logic [13:0]   sy1;
    logic [13:0]   sy2;
    logic [13:0]   sy3;
    logic [13:0]   lvl;
    logic [13:0]   lvl_d;
    logic          ext_edge_d;
    logic [1:0]    div4;
    logic [2:0]    pre;
    logic [15:0]   cnt;
    logic [7:0]    hbuf;
    logic [1:0]    prescale_ratio;
    logic          sync_off;
    logic          wide_access_enable;
    logic          run;
    logic          gate_function_enable;
    logic          gate_polarity;
    logic          gate_toggle_mode;
    logic          gate_single_pulse_mode;
    logic          pulse_acquire_flag;
    logic [4:0]    gate_input_choice;
    logic [4:0]    clock_choice;
    logic          gp_d;
    logic          tff;
    logic          gt_d;
    logic          sp_act;
    logic          gate_level_status_d;
    logic          overflow_flag;
    logic          gate_event_flag;
    gtr_wr_state_t wst;
    logic          aw_got;
    logic          w_got;
    logic [9:0]    waddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    gtr_rd_state_t rst;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } gtr_state_t;
endpackage

/* src/gtr_timer.sv */
`timescale 1ns/100ps
`include "gtr_map.svh"
// What this block does
// - Prescale field divides count clock by 1, 2, 4 or 8 for codes 00-11.
// - System or instruction clock ignores the sync bit, counts directly.
// - Other sources: sync bit 0 resynchronizes count input, 1 passes it.
// - Wide access bit makes counter reads and writes one 16-bit operation.
// - With run set, gate enable lets the gate control counting.
// - Run set, gate enable clear: count every prescaled tick, ignore gate.
// - Gate polarity 1 counts while gate high, 0 while gate low.
// - Toggle mode routes gate through a flip-flop toggling on rising edges.
// - Single-pulse mode bit puts the gate under pulse acquisition control.
// - Clearing single-pulse mode clears the go/done bit in hardware.
// - Go/done reads 1 while armed and waiting, 0 when done or unstarted.
// - Read-only bit shows conditioned gate level, even with enable off.
// - Five-bit clock select picks count clock; 01001 and above reserved.
// - Five-bit gate select picks gate source; 00111 and above reserved.
// - Counter is readable and writable whole and as high and low bytes.
// - Power-on reset clears all selection, control fields and the counter.
// - Pulse trailing edge clears go/done; counting blocked until re-armed.
// - Counter wraps from maximum to zero and sets the overflow flag.
// - A gate level fall sets the gate-event flag, even with gate off.
module gtr_timer (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Count clock and gate sources
  input  wire gtr_pkg::gtr_clk_src_t  clk_sources,
  input  wire gtr_pkg::gtr_gate_src_t gate_sources,
  // AXI4-Lite write address and data
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [11:0]            awaddr,
  input  wire logic [2:0]             awprot,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  // AXI4-Lite write response
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // AXI4-Lite read
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [11:0]            araddr,
  input  wire logic [2:0]             arprot,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // Timebase and event flags for neighbouring logic
  output logic [15:0]                 count_value,
  output logic                        overflow_flag,
  output logic                        gate_event_flag
);
  gtr_pkg::gtr_state_t s;
  gtr_pkg::gtr_state_t next_s;
  logic [13:0]         agreed;
  logic                ext_lvl;
  logic                ext_edge;
  logic                is_int;
  logic                raw_edge;
  logic [2:0]          ps_mask;
  logic                tick;
  logic                gate_raw;
  logic                gp;
  logic                gt;
  logic                gate_level_status;
  logic                inc;
  logic                wr_do;
  logic                wr_cnt;
  logic                rd_do;
  logic [31:0]         rd_val;
  logic                rd_hit;

  // Agreement filter: a source change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 14; gi++) begin : g_filt
      assign agreed[gi] = (s.sy2[gi] == s.sy3[gi]) ? s.sy3[gi] : s.lvl[gi];
    end
  endgenerate

  always_comb begin
    next_s   = s;
    // Three-stage capture of every outside source
    next_s.sy1   = {gate_sources, clk_sources};
    next_s.sy2   = s.sy1;
    next_s.sy3   = s.sy2;
    next_s.lvl   = agreed;
    next_s.lvl_d = s.lvl;
    next_s.div4  = s.div4 + 2'h1;

    // Count clock selection, reserved codes select nothing
    ext_lvl = 1'b0;
    is_int  = 1'b0;
    case (s.clock_choice)
      `GTR_CS_PIN:         ext_lvl = s.lvl[0];
      `GTR_CS_SMALL_TIMER: ext_lvl = s.lvl[1];
      `GTR_CS_FAST:        ext_lvl = s.lvl[2];
      `GTR_CS_SLOW:        ext_lvl = s.lvl[3];
      `GTR_CS_MED_500K:    ext_lvl = s.lvl[4];
      `GTR_CS_MED_32K:     ext_lvl = s.lvl[5];
      `GTR_CS_ONE_MHZ:     ext_lvl = s.lvl[6];
      `GTR_CS_INSTR,
      `GTR_CS_SYSTEM:      is_int = 1'b1;
      default:             ext_lvl = 1'b0;
    endcase
    ext_edge = 1'b0;
    if (s.clock_choice <= `GTR_CS_SMALL_TIMER && !is_int) begin
      ext_edge = ext_lvl & ~(s.lvl_d[s.clock_choice == `GTR_CS_PIN ? 0 :
        s.clock_choice == `GTR_CS_SMALL_TIMER ? 1 :
        s.clock_choice == `GTR_CS_FAST ? 2 :
        s.clock_choice == `GTR_CS_SLOW ? 3 :
        s.clock_choice == `GTR_CS_MED_500K ? 4 :
        s.clock_choice == `GTR_CS_MED_32K ? 5 : 6]);
    end
    next_s.ext_edge_d = ext_edge;
    // Resync costs one extra cycle of latency on the count edge
    if (s.clock_choice == `GTR_CS_SYSTEM)
      raw_edge = 1'b1;
    else if (s.clock_choice == `GTR_CS_INSTR)
      raw_edge = (s.div4 == `GTR_INSTR_DIV_LAST);
    else if (s.sync_off)
      raw_edge = ext_edge;
    else
      raw_edge = s.ext_edge_d;

    // Prescaler
    ps_mask = 3'((4'h1 << s.prescale_ratio) - 4'h1);
    tick    = raw_edge && ((s.pre & ps_mask) == ps_mask);
    if (raw_edge)
      next_s.pre = s.pre + 3'h1;

    // Gate conditioning
    case (s.gate_input_choice)
      `GTR_GS_PIN:          gate_raw = s.lvl[7];
      `GTR_GS_SMALL_TIMER:  gate_raw = s.lvl[8];
      `GTR_GS_PERIOD_TIMER: gate_raw = s.lvl[9];
      `GTR_GS_CAPCOMP_ONE:  gate_raw = s.lvl[10];
      `GTR_GS_CAPCOMP_TWO:  gate_raw = s.lvl[11];
      `GTR_GS_PWM_THREE:    gate_raw = s.lvl[12];
      `GTR_GS_PWM_FOUR:     gate_raw = s.lvl[13];
      default:              gate_raw = 1'b0;
    endcase
    gp          = s.gate_polarity ? gate_raw : ~gate_raw;
    next_s.gp_d = gp;
    next_s.tff  = s.gate_toggle_mode ? (s.tff ^ (gp & ~s.gp_d)) : 1'b0;
    gt          = s.gate_toggle_mode ? s.tff : gp;
    next_s.gt_d = gt;
    // Armed acquisition opens on a leading edge, closes on the trailing one
    next_s.sp_act = s.gate_single_pulse_mode && s.pulse_acquire_flag &&
                    (s.sp_act || (gt && !s.gt_d));
    gate_level_status = s.gate_single_pulse_mode ? (s.sp_act && gt) : gt;
    next_s.gate_level_status_d = gate_level_status;
    if (s.gate_single_pulse_mode && s.sp_act && !gt && s.gt_d)
      next_s.pulse_acquire_flag = 1'b0;
    if (s.gate_level_status_d && !gate_level_status)
      next_s.gate_event_flag = 1'b1;

    // Counting
    inc = s.run && tick && (!s.gate_function_enable || gate_level_status);
    if (inc) begin
      next_s.cnt = s.cnt + 16'h1;
      if (s.cnt == `GTR_COUNT_MAX)
        next_s.overflow_flag = 1'b1;
    end

    // AXI write: address and data captured in either order
    if (awvalid && s.awready) begin
      next_s.aw_got  = 1'b1;
      next_s.awready = 1'b0;
      next_s.waddr   = awaddr[11:2];
    end
    if (wvalid && s.wready) begin
      next_s.w_got  = 1'b1;
      next_s.wready = 1'b0;
      next_s.wdata  = wdata;
      next_s.wstrb  = wstrb;
    end
    wr_do  = (s.wst == gtr_pkg::WR_IDLE) && s.aw_got && s.w_got;
    wr_cnt = 1'b0;
    case (s.wst)
      gtr_pkg::WR_IDLE: begin
        if (wr_do) begin
          next_s.wst    = gtr_pkg::WR_RESP;
          next_s.aw_got = 1'b0;
          next_s.w_got  = 1'b0;
          next_s.bvalid = 1'b1;
          next_s.bresp  = `GTR_RESP_OKAY;
          case (s.waddr)
            `GTR_IDX_COUNT_VALUE: begin
              wr_cnt = s.wstrb[0] || s.wstrb[1];
              if (s.wstrb[0]) begin
                next_s.cnt[7:0] = s.wdata[7:0];
                if (s.wide_access_enable && !s.wstrb[1])
                  next_s.cnt[15:8] = s.hbuf;
              end
              if (s.wstrb[1])
                next_s.cnt[15:8] = s.wdata[15:8];
            end
            `GTR_IDX_COUNT_HIGH: begin
              if (s.wstrb[0] && s.wide_access_enable)
                next_s.hbuf = s.wdata[7:0];
              else if (s.wstrb[0]) begin
                next_s.cnt[15:8] = s.wdata[7:0];
                wr_cnt = 1'b1;
              end
            end
            `GTR_IDX_TIMER_CTRL: begin
              if (s.wstrb[0]) begin
                next_s.prescale_ratio     =
                  s.wdata[`GTR_TC_PS_LSB+1:`GTR_TC_PS_LSB];
                next_s.sync_off           = s.wdata[`GTR_TC_SYNC];
                next_s.wide_access_enable = s.wdata[`GTR_TC_WIDE];
                next_s.run                = s.wdata[`GTR_TC_RUN];
              end
            end
            `GTR_IDX_GATE_CTRL: begin
              if (s.wstrb[0]) begin
                next_s.gate_function_enable   = s.wdata[`GTR_GC_GE];
                next_s.gate_polarity          = s.wdata[`GTR_GC_GATE_POLARITY];
                next_s.gate_toggle_mode       = s.wdata[`GTR_GC_GTM];
                next_s.gate_single_pulse_mode = s.wdata[`GTR_GC_GATE_SINGLE_PULSE_MODE];
                next_s.pulse_acquire_flag     = s.wdata[`GTR_GC_GO];
              end
            end
            `GTR_IDX_GATE_SRC:
              if (s.wstrb[0])
                next_s.gate_input_choice = s.wdata[4:0];
            `GTR_IDX_CLK_SRC:
              if (s.wstrb[0])
                next_s.clock_choice = s.wdata[4:0];
            `GTR_IDX_EVENT_STATUS: begin
              // Write one to clear; a same-cycle event still sets
              if (s.wstrb[0] && s.wdata[`GTR_ST_OVF] &&
                  !(inc && s.cnt == `GTR_COUNT_MAX))
                next_s.overflow_flag = 1'b0;
              if (s.wstrb[0] && s.wdata[`GTR_ST_GEVT] &&
                  !(s.gate_level_status_d && !gate_level_status))
                next_s.gate_event_flag = 1'b0;
            end
            default: next_s.bresp = `GTR_RESP_DECERR;
          endcase
        end
      end
      gtr_pkg::WR_RESP: begin
        if (bready) begin
          next_s.wst     = gtr_pkg::WR_IDLE;
          next_s.bvalid  = 1'b0;
          next_s.awready = 1'b1;
          next_s.wready  = 1'b1;
        end
      end
      default: next_s.wst = gtr_pkg::WR_IDLE;
    endcase
    // Software write beats a count in the same cycle
    if (wr_cnt && inc && s.cnt == `GTR_COUNT_MAX && !s.overflow_flag)
      next_s.overflow_flag = 1'b1;
    // Go/done exists only inside single-pulse mode
    if (!next_s.gate_single_pulse_mode)
      next_s.pulse_acquire_flag = 1'b0;

    // AXI read
    rd_hit = 1'b1;
    case (araddr[11:2])
      `GTR_IDX_COUNT_VALUE:  rd_val = {16'h0, s.cnt};
      `GTR_IDX_COUNT_HIGH:
        rd_val = {24'h0, s.wide_access_enable ? s.hbuf : s.cnt[15:8]};
      `GTR_IDX_TIMER_CTRL:
        rd_val = {26'h0, s.prescale_ratio, 1'b0, s.sync_off,
                  s.wide_access_enable, s.run};
      `GTR_IDX_GATE_CTRL:
        rd_val = {24'h0, s.gate_function_enable, s.gate_polarity,
                  s.gate_toggle_mode, s.gate_single_pulse_mode,
                  s.pulse_acquire_flag, gate_level_status, 2'h0};
      `GTR_IDX_GATE_SRC:     rd_val = {27'h0, s.gate_input_choice};
      `GTR_IDX_CLK_SRC:      rd_val = {27'h0, s.clock_choice};
      `GTR_IDX_EVENT_STATUS:
        rd_val = {30'h0, s.gate_event_flag, s.overflow_flag};
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
    rd_do = (s.rst == gtr_pkg::RD_IDLE) && arvalid && s.arready;
    case (s.rst)
      gtr_pkg::RD_IDLE: begin
        if (rd_do) begin
          next_s.rst     = gtr_pkg::RD_DATA;
          next_s.arready = 1'b0;
          next_s.rvalid  = 1'b1;
          next_s.rdata   = rd_val;
          next_s.rresp   = rd_hit ? `GTR_RESP_OKAY : `GTR_RESP_DECERR;
          if (araddr[11:2] == `GTR_IDX_COUNT_VALUE && s.wide_access_enable)
            next_s.hbuf = s.cnt[15:8];
        end
      end
      gtr_pkg::RD_DATA: begin
        if (rready) begin
          next_s.rst     = gtr_pkg::RD_IDLE;
          next_s.rvalid  = 1'b0;
          next_s.arready = 1'b1;
        end
      end
      default: next_s.rst = gtr_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign awready         = s.awready;
  assign wready          = s.wready;
  assign bvalid          = s.bvalid;
  assign bresp           = s.bresp;
  assign arready         = s.arready;
  assign rvalid          = s.rvalid;
  assign rdata           = s.rdata;
  assign rresp           = s.rresp;
  assign count_value     = s.cnt;
  assign overflow_flag   = s.overflow_flag;
  assign gate_event_flag = s.gate_event_flag;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence sq_ext_rise;
    !is_int && !s.sync_off && ext_edge;
  endsequence
  sequence sq_still_sync;
    !is_int && !s.sync_off;
  endsequence

  property p_presc;
    tick && s.prescale_ratio != 2'h0 && !wr_do |=> !tick;
  endproperty
  a_presc: assert property (p_presc) else $error("tick off prescale");
  property p_sysclk;
    s.clock_choice == `GTR_CS_SYSTEM && s.prescale_ratio == 2'h0 |-> tick;
  endproperty
  a_sysclk: assert property (p_sysclk) else $error("no system edge");
  property p_resync;
    sq_ext_rise ##1 sq_still_sync |-> raw_edge;
  endproperty
  a_resync: assert property (p_resync) else $error("resync lost");
  property p_free_count;
    s.run && !s.gate_function_enable && tick && !wr_do &&
      s.cnt != `GTR_COUNT_MAX |=> s.cnt == $past(s.cnt) + 16'h1;
  endproperty
  a_free_count: assert property (p_free_count) else $error("no count");
  property p_gate_block;
    s.run && s.gate_function_enable && !gate_level_status && !wr_do |=> $stable(s.cnt);
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("gate leak");
  property p_tff_clear;
    !s.gate_toggle_mode |=> !s.tff;
  endproperty
  a_tff_clear: assert property (p_tff_clear) else $error("tff set");
  property p_go_mode;
    !s.gate_single_pulse_mode |-> !s.pulse_acquire_flag;
  endproperty
  a_go_mode: assert property (p_go_mode) else $error("go left on");
  property p_trail;
    s.gate_single_pulse_mode && s.sp_act && !gt && s.gt_d && !wr_do
      |=> !s.pulse_acquire_flag ##1 !s.sp_act;
  endproperty
  a_trail: assert property (p_trail) else $error("go not done");
  property p_wrap;
    inc && s.cnt == `GTR_COUNT_MAX && !wr_cnt
      |=> s.cnt == 16'h0 && s.overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad wrap");
  property p_gevt;
    s.gate_level_status_d && !gate_level_status |=> s.gate_event_flag;
  endproperty
  a_gevt: assert property (p_gevt) else $error("gate event lost");
  property p_latch;
    rd_do && araddr[11:2] == `GTR_IDX_COUNT_VALUE && s.wide_access_enable
      |=> s.hbuf == $past(s.cnt[15:8]);
  endproperty
  a_latch: assert property (p_latch) else $error("no latch");
endmodule

/* tb/gtr_src_model.sv */
`timescale 1ns/100ps
module gtr_src_model (
  // Clock
  input  wire logic            aclk,
  // Gate levels chosen by the bench
  input  wire logic [6:0]      gate_lvl,
  // Sources towards the timer
  output gtr_pkg::gtr_clk_src_t  clk_sources,
  output gtr_pkg::gtr_gate_src_t gate_sources
);
  // Free-running divider; the bench derives expected counts from its taps
  logic [7:0] div = 8'h00;
  always @(posedge aclk) div <= div + 8'h01;
  assign clk_sources  = {div[3], div[6], div[4], div[5], div[2], div[3],
                         div[3]};
  assign gate_sources = gate_lvl;
endmodule

/* tb/gated_timer_register_set_bench.sv */
`timescale 1ns/100ps
`include "gtr_map.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module gated_timer_register_set_bench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, resp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        overflow_flag, gate_event_flag;
  logic [15:0] count_value, cnt, dl;
  logic [6:0]  gate_lvl = 7'h00;
  gtr_pkg::gtr_clk_src_t  clk_src;
  gtr_pkg::gtr_gate_src_t gate_src;
  int error_cnt = 0, num_checks = 0, cyc = 0, seed = 32343, i, j, v;
  // Source periods in clock cycles per select code; 0 marks a core clock
  int per[$] = '{16, 0, 0, 8, 64, 16, 32, 128, 16};
  initial forever #25 aclk = ~aclk;
  gtr_src_model src (.aclk(aclk), .gate_lvl(gate_lvl),
    .clk_sources(clk_src), .gate_sources(gate_src));
  gtr_timer uut (.aclk(aclk), .aresetn(aresetn), .clk_sources(clk_src),
    .gate_sources(gate_src), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(1'b1),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(1'b1), .rdata(rdata),
    .rresp(rresp), .count_value(count_value),
    .overflow_flag(overflow_flag), .gate_event_flag(gate_event_flag));
  task automatic complete_run();
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [9:0] idx, input logic [31:0] val,
                    input logic [3:0] s);
    logic aw_on, w_on;
    awaddr <= {idx, 2'b00};
    wdata <= val;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_on = 1'b1;
    w_on = 1'b1;
    while (aw_on || w_on) begin
      @(posedge aclk);
      if (aw_on && awready === 1'b1) begin
        aw_on = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        w_on = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask
  task automatic rd(input logic [9:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
  endtask
  // Settle, then count increments over a window of 128 cycles
  task automatic meas();
    repeat (16) @(posedge aclk);
    cnt = count_value;
    repeat (128) @(posedge aclk);
    dl = count_value - cnt;
  endtask
  task automatic pulse();
    gate_lvl <= 7'h01;
    repeat (16) @(posedge aclk);
    gate_lvl <= 7'h00;
    repeat (16) @(posedge aclk);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 7; i++) begin
      rd(10'(`GTR_IDX_COUNT_VALUE + i));
      `CHK(d & 32'hffff_fffb, 32'h0)
    end
    rd(10'h213);
    `CHK(resp, `GTR_RESP_DECERR)
    wr(10'h213, 32'h1, 4'hf);
    `CHK(resp, `GTR_RESP_DECERR)
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(`GTR_IDX_TIMER_CTRL, v & 32'h36, 4'h1);
      rd(`GTR_IDX_TIMER_CTRL);
      `CHK(d, 32'(v & 32'h36))
      wr(`GTR_IDX_GATE_CTRL, v & 32'he0, 4'h1);
      rd(`GTR_IDX_GATE_CTRL);
      `CHK(d & 32'hfb, 32'(v & 32'he0))
      wr(`GTR_IDX_GATE_SRC, (v >> 8) & 32'h1f, 4'h1);
      rd(`GTR_IDX_GATE_SRC);
      `CHK(d, 32'((v >> 8) & 32'h1f))
      wr(`GTR_IDX_CLK_SRC, (v >> 16) & 32'h1f, 4'h1);
      rd(`GTR_IDX_CLK_SRC);
      `CHK(d, 32'((v >> 16) & 32'h1f))
    end
    wr(`GTR_IDX_TIMER_CTRL, 32'h0, 4'h1);
    wr(`GTR_IDX_GATE_CTRL, 32'h0, 4'h1);
    v = $random(seed) & 32'hffff;
    wr(`GTR_IDX_COUNT_VALUE, v, 4'h3);
    rd(`GTR_IDX_COUNT_VALUE);
    `CHK(d, 32'(v))
    wr(`GTR_IDX_COUNT_HIGH, 32'h5a, 4'h1);
    wr(`GTR_IDX_COUNT_VALUE, 32'h3c, 4'h1);
    rd(`GTR_IDX_COUNT_VALUE);
    `CHK(d, 32'h5a3c)
    // Wide mode: high byte waits for the low byte, low read latches high
    wr(`GTR_IDX_TIMER_CTRL, 32'h2, 4'h1);
    wr(`GTR_IDX_COUNT_HIGH, 32'ha7, 4'h1);
    // Watch the live port: a read here would refill the shared buffer
    `CHK(count_value, 16'h5a3c)
    wr(`GTR_IDX_COUNT_VALUE, 32'h19, 4'h1);
    rd(`GTR_IDX_COUNT_VALUE);
    `CHK(d, 32'ha719)
    wr(`GTR_IDX_COUNT_VALUE, 32'h1234, 4'h3);
    rd(`GTR_IDX_COUNT_HIGH);
    `CHK(d, 32'ha7)
    for (j = 1; j < 3; j++) begin
      wr(`GTR_IDX_CLK_SRC, j, 4'h1);
      for (i = 0; i < 4; i++) begin
        wr(`GTR_IDX_TIMER_CTRL, (i << 4) | ($random(seed) & 4) | 1, 4'h1);
        meas();
        `CHK(dl, 16'((j == 2 ? 128 : 32) >> i))
      end
    end
    for (i = 0; i < 9; i++) begin
      if (per[i] != 0) begin
        wr(`GTR_IDX_CLK_SRC, i, 4'h1);
        wr(`GTR_IDX_TIMER_CTRL, ((i & 1) << 2) | 1, 4'h1);
        meas();
        `CHK(dl, 16'(128 / per[i]))
      end
    end
    wr(`GTR_IDX_CLK_SRC, ($random(seed) & 7) + 9, 4'h1);
    meas();
    `CHK(dl, 16'h0)
    wr(`GTR_IDX_CLK_SRC, 32'h2, 4'h1);
    wr(`GTR_IDX_TIMER_CTRL, 32'h1, 4'h1);
    for (i = 0; i < 4; i++) begin
      j = ($random(seed) & 32'h7fff) % 7;
      wr(`GTR_IDX_GATE_SRC, j, 4'h1);
      wr(`GTR_IDX_GATE_CTRL, 32'h80 | ((i & 1) << 6), 4'h1);
      gate_lvl <= 7'((i >> 1) << j);
      meas();
      `CHK(dl, 16'(((i & 1) == (i >> 1)) ? 128 : 0))
    end
    wr(`GTR_IDX_TIMER_CTRL, 32'h0, 4'h1);
    meas();
    `CHK(dl, 16'h0)
    wr(`GTR_IDX_TIMER_CTRL, 32'h1, 4'h1);
    wr(`GTR_IDX_GATE_SRC, 32'h7, 4'h1);
    gate_lvl <= 7'h7f;
    meas();
    `CHK(dl, 16'h0)
    wr(`GTR_IDX_GATE_SRC, 32'h0, 4'h1);
    wr(`GTR_IDX_GATE_CTRL, 32'h40, 4'h1);
    rd(`GTR_IDX_GATE_CTRL);
    `CHK(d[2], 1'b1)
    wr(`GTR_IDX_EVENT_STATUS, 32'h3, 4'h1);
    gate_lvl <= 7'h00;
    repeat (16) @(posedge aclk);
    rd(`GTR_IDX_GATE_CTRL);
    `CHK(d[2], 1'b0)
    `CHK(gate_event_flag, 1'b1)
    wr(`GTR_IDX_GATE_CTRL, 32'h60, 4'h1);
    for (i = 0; i < 3; i++) begin
      pulse();
      rd(`GTR_IDX_GATE_CTRL);
      `CHK(d[2], ~i[0])
    end
    wr(`GTR_IDX_GATE_CTRL, 32'h40, 4'h1);
    wr(`GTR_IDX_GATE_CTRL, 32'h60, 4'h1);
    rd(`GTR_IDX_GATE_CTRL);
    `CHK(d[2], 1'b0)
    wr(`GTR_IDX_GATE_CTRL, 32'hd0, 4'h1);
    wr(`GTR_IDX_GATE_CTRL, 32'hd8, 4'h1);
    rd(`GTR_IDX_GATE_CTRL);
    `CHK(d[3], 1'b1)
    gate_lvl <= 7'h01;
    meas();
    `CHK(dl, 16'd128)
    gate_lvl <= 7'h00;
    repeat (16) @(posedge aclk);
    rd(`GTR_IDX_GATE_CTRL);
    `CHK(d[3], 1'b0)
    gate_lvl <= 7'h01;
    meas();
    `CHK(dl, 16'h0)
    wr(`GTR_IDX_GATE_CTRL, 32'hd8, 4'h1);
    wr(`GTR_IDX_GATE_CTRL, 32'hc8, 4'h1);
    rd(`GTR_IDX_GATE_CTRL);
    `CHK(d[3], 1'b0)
    wr(`GTR_IDX_GATE_CTRL, 32'h0, 4'h1);
    wr(`GTR_IDX_TIMER_CTRL, 32'h0, 4'h1);
    wr(`GTR_IDX_EVENT_STATUS, 32'h3, 4'h1);
    wr(`GTR_IDX_COUNT_VALUE, 32'hfff0, 4'h3);
    `CHK(overflow_flag, 1'b0)
    wr(`GTR_IDX_TIMER_CTRL, 32'h1, 4'h1);
    repeat (40) @(posedge aclk);
    `CHK(overflow_flag, 1'b1)
    `CHK(count_value < 16'h0040, 1'b1)
    complete_run();
  end
endmodule
